// *** shared/pwr_mode_consts.svh ***
// Constants for the CPU power-mode control block
`ifndef PWR_MODE_CONSTS_SVH
`define PWR_MODE_CONSTS_SVH

`define ADDR_W 4
`define DATA_W 8
`define ADDR_DOZE_CTRL 4'h0
`define ADDR_VREG_CTRL 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_WAKE_CAUSE 4'h3
`define DOZE_IDLE_BIT 7
`define DOZE_EN_BIT 6
`define DOZE_ROI_BIT 5
`define DOZE_DOE_BIT 4
`define DOZE_RATIO_HI 2
`define VREG_LP_BIT 1
`define VREG_RSVD_BIT 0
`define DOZE_CTRL_RST 8'h00
`define VREG_CTRL_RST 8'h01
`define RATIO_W 3
`define DOZE_CNT_W 8
`define IRQ_VECTOR 16'h0004
`define OST_PERIODS 1024
`define VREG_STAB_NS 2000
`define CLK_PERIOD_NS 20
`define WAIT_CNT_W 12
`define VREG_STAB_CYC ((`VREG_STAB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** shared/pwr_mode_pkg.sv ***
// Types for the CPU power-mode control block
package pwr_mode_pkg;
	typedef enum logic [2:0] {
		ST_RUN,
		ST_SLEEP,
		ST_IDLE,
		ST_OST_WAIT,
		ST_VREG_WAIT
	} pwr_state_t;
endpackage

// *** hdl/cpu_power_mode_control.sv ***
// CPU power-mode control: doze throttling, Sleep, Idle and wake-up sequencing
`timescale 1ns/1ps
`default_nettype none
`include "pwr_mode_consts.svh"

module cpu_power_mode_control (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [`ADDR_W-1:0] reg_addr_i,
	input wire logic [`DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [`DATA_W-1:0] reg_rdata_o,
	input wire logic sleep_instr_i,
	input wire logic irq_entry_i,
	input wire logic return_from_irq_instr_i,
	input wire logic irq_pending_i,
	input wire logic global_irq_enable_i,
	input wire logic wdt_timeout_i,
	input wire logic wdt_sleep_enable_i,
	input wire logic crystal_mode_i,
	input wire logic clock_output_pin_enable_i,
	output logic core_clk_en_o,
	output logic periph_clk_en_o,
	output logic sysosc_periph_en_o,
	output logic lowfreq_osc_en_o,
	output logic io_hold_o,
	output logic wdt_clear_o,
	output logic wdt_reset_block_o,
	output logic regulator_lowpower_o,
	output logic clock_output_pin_en_o,
	output logic wake_pulse_o,
	output logic vector_to_handler_o,
	output logic [15:0] handler_addr_o,
	output logic powerdown_flag_o,
	output logic timeout_flag_o
);

	pwr_mode_pkg::pwr_state_t state_reg;
	logic halt_core_select_reg;
	logic cpu_throttle_enable_reg;
	logic restore_on_irq_reg;
	logic throttle_on_return_reg;
	logic [`RATIO_W-1:0] throttle_ratio_select_reg;
	logic regulator_lowpower_select_reg;
	logic [`DOZE_CNT_W-1:0] doze_cnt_reg;
	logic [`WAIT_CNT_W-1:0] wait_cnt_reg;
	logic [2:0] wake_cause_reg;
	logic irq_s1_reg, irq_s2_reg, wdt_s1_reg, wdt_s2_reg;
	logic pending_wake_reg;

	// Divider terminal count for the throttle ratio (2 << sel) - 1
	function automatic logic [`DOZE_CNT_W-1:0] ratio_last(input logic [`RATIO_W-1:0] sel);
		logic [8:0] n;
		n = 9'h002 << sel;
		ratio_last = 8'(n - 9'h001);
	endfunction

	wire logic wr_doze = reg_wr_i && (reg_addr_i == `ADDR_DOZE_CTRL);
	wire logic wr_vreg = reg_wr_i && (reg_addr_i == `ADDR_VREG_CTRL);
	wire logic in_run = (state_reg == pwr_mode_pkg::ST_RUN);
	wire logic sleep_go = in_run && sleep_instr_i;
	wire logic pend_now = irq_s2_reg;
	wire logic doze_slot = !cpu_throttle_enable_reg || (doze_cnt_reg == 8'h00);
	wire logic [`WAIT_CNT_W-1:0] ost_last = 12'(`OST_PERIODS - 1);
	wire logic [`WAIT_CNT_W-1:0] vreg_last = 12'(`VREG_STAB_CYC - 1);

	// Interrupt pending and watchdog timeout come from outside this clock domain
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_s1_reg <= 1'b0;
			irq_s2_reg <= 1'b0;
			wdt_s1_reg <= 1'b0;
			wdt_s2_reg <= 1'b0;
		end else begin
			irq_s1_reg <= irq_pending_i;
			irq_s2_reg <= irq_s1_reg;
			wdt_s1_reg <= wdt_timeout_i;
			wdt_s2_reg <= wdt_s1_reg;
		end
	end

	// Software control bits
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			halt_core_select_reg <= 1'b0;
			restore_on_irq_reg <= 1'b0;
			throttle_on_return_reg <= 1'b0;
			throttle_ratio_select_reg <= 3'h0;
			regulator_lowpower_select_reg <= 1'b0;
		end else begin
			if (wr_doze) begin
				halt_core_select_reg <= reg_wdata_i[`DOZE_IDLE_BIT];
				restore_on_irq_reg <= reg_wdata_i[`DOZE_ROI_BIT];
				throttle_on_return_reg <= reg_wdata_i[`DOZE_DOE_BIT];
				throttle_ratio_select_reg <= reg_wdata_i[`DOZE_RATIO_HI:0];
			end
			if (wr_vreg) begin
				regulator_lowpower_select_reg <= reg_wdata_i[`VREG_LP_BIT];
			end
		end
	end

	// Throttle enable: hardware set/clear on interrupt entry and return win over software
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cpu_throttle_enable_reg <= 1'b0;
		end else if (restore_on_irq_reg && (irq_entry_i || (state_reg == pwr_mode_pkg::ST_IDLE && pend_now))) begin
			cpu_throttle_enable_reg <= 1'b0;
		end else if (return_from_irq_instr_i && throttle_on_return_reg) begin
			cpu_throttle_enable_reg <= 1'b1;
		end else if (wr_doze) begin
			cpu_throttle_enable_reg <= reg_wdata_i[`DOZE_EN_BIT];
		end
	end

	// Doze divider counts peripheral cycles between core slots
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			doze_cnt_reg <= 8'h00;
		end else if (!cpu_throttle_enable_reg || !in_run) begin
			doze_cnt_reg <= 8'h00;
		end else if (doze_cnt_reg >= ratio_last(throttle_ratio_select_reg)) begin
			doze_cnt_reg <= 8'h00;
		end else begin
			doze_cnt_reg <= doze_cnt_reg + 8'h01;
		end
	end

	// Power state machine
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= pwr_mode_pkg::ST_RUN;
			wait_cnt_reg <= 12'h000;
			pending_wake_reg <= 1'b0;
		end else begin
			pending_wake_reg <= 1'b0;
			case (state_reg)
				pwr_mode_pkg::ST_RUN: begin
					if (sleep_go && !pend_now) begin
						if (halt_core_select_reg) begin
							state_reg <= pwr_mode_pkg::ST_IDLE;
						end else begin
							state_reg <= pwr_mode_pkg::ST_SLEEP;
						end
					end
				end
				pwr_mode_pkg::ST_SLEEP: begin
					if (pend_now || (wdt_s2_reg && wdt_sleep_enable_i)) begin
						wait_cnt_reg <= 12'h000;
						pending_wake_reg <= pend_now;
						if (crystal_mode_i) begin
							state_reg <= pwr_mode_pkg::ST_OST_WAIT;
						end else if (regulator_lowpower_select_reg) begin
							state_reg <= pwr_mode_pkg::ST_VREG_WAIT;
						end else begin
							state_reg <= pwr_mode_pkg::ST_RUN;
						end
					end
				end
				pwr_mode_pkg::ST_OST_WAIT: begin
					pending_wake_reg <= pending_wake_reg;
					if (wait_cnt_reg == ost_last) begin
						wait_cnt_reg <= 12'h000;
						state_reg <= regulator_lowpower_select_reg ? pwr_mode_pkg::ST_VREG_WAIT
							: pwr_mode_pkg::ST_RUN;
					end else begin
						wait_cnt_reg <= wait_cnt_reg + 12'h001;
					end
				end
				pwr_mode_pkg::ST_VREG_WAIT: begin
					pending_wake_reg <= pending_wake_reg;
					if (wait_cnt_reg >= vreg_last) begin
						state_reg <= pwr_mode_pkg::ST_RUN;
					end else begin
						wait_cnt_reg <= wait_cnt_reg + 12'h001;
					end
				end
				pwr_mode_pkg::ST_IDLE: begin
					if (pend_now || wdt_s2_reg) begin
						pending_wake_reg <= pend_now;
						state_reg <= pwr_mode_pkg::ST_RUN;
					end
				end
				default: begin
					state_reg <= pwr_mode_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Status flags: powerdown and timeout, kept when sleep is a no-op
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			powerdown_flag_o <= 1'b1;
			timeout_flag_o <= 1'b1;
		end else if (sleep_go && !pend_now) begin
			powerdown_flag_o <= 1'b0;
			timeout_flag_o <= 1'b1;
		end
	end

	// Wake cause capture: bit0 interrupt, bit1 watchdog, bit2 sleep skipped as no-op
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wake_cause_reg <= 3'h0;
		end else if (sleep_go && pend_now) begin
			wake_cause_reg <= 3'h4;
		end else if (!in_run && (pend_now || wdt_s2_reg) &&
			(state_reg == pwr_mode_pkg::ST_SLEEP || state_reg == pwr_mode_pkg::ST_IDLE)) begin
			wake_cause_reg <= {1'b0, wdt_s2_reg, pend_now};
		end
	end

	// Clock, watchdog and handler outputs
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			core_clk_en_o <= 1'b1;
			periph_clk_en_o <= 1'b1;
			sysosc_periph_en_o <= 1'b1;
			lowfreq_osc_en_o <= 1'b1;
			io_hold_o <= 1'b0;
			wdt_clear_o <= 1'b0;
			wdt_reset_block_o <= 1'b0;
			regulator_lowpower_o <= 1'b0;
			clock_output_pin_en_o <= 1'b0;
			wake_pulse_o <= 1'b0;
			vector_to_handler_o <= 1'b0;
			handler_addr_o <= 16'h0000;
		end else begin
			core_clk_en_o <= in_run && doze_slot && !(sleep_go && !pend_now);
			periph_clk_en_o <= 1'b1;
			sysosc_periph_en_o <= (state_reg != pwr_mode_pkg::ST_SLEEP);
			lowfreq_osc_en_o <= 1'b1;
			io_hold_o <= (state_reg == pwr_mode_pkg::ST_SLEEP);
			wdt_clear_o <= (sleep_go && !pend_now && !halt_core_select_reg)
				|| ((state_reg == pwr_mode_pkg::ST_SLEEP) && (pend_now || (wdt_s2_reg && wdt_sleep_enable_i)));
			wdt_reset_block_o <= (state_reg == pwr_mode_pkg::ST_IDLE);
			regulator_lowpower_o <= regulator_lowpower_select_reg
				&& (state_reg == pwr_mode_pkg::ST_SLEEP);
			clock_output_pin_en_o <= clock_output_pin_enable_i
				&& (state_reg != pwr_mode_pkg::ST_SLEEP);
			wake_pulse_o <= !in_run && (state_reg != pwr_mode_pkg::ST_SLEEP) && (state_reg != pwr_mode_pkg::ST_IDLE)
				? 1'b0 : 1'b0;
			if ((state_reg == pwr_mode_pkg::ST_IDLE && (pend_now || wdt_s2_reg))
				|| (state_reg == pwr_mode_pkg::ST_SLEEP && !crystal_mode_i && !regulator_lowpower_select_reg
				&& (pend_now || (wdt_s2_reg && wdt_sleep_enable_i)))
				|| ((state_reg == pwr_mode_pkg::ST_OST_WAIT) && (wait_cnt_reg == ost_last)
				&& !regulator_lowpower_select_reg)
				|| ((state_reg == pwr_mode_pkg::ST_VREG_WAIT) && (wait_cnt_reg >= vreg_last))) begin
				wake_pulse_o <= 1'b1;
			end
			vector_to_handler_o <= pending_wake_reg && in_run && global_irq_enable_i;
			handler_addr_o <= `IRQ_VECTOR;
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`ADDR_DOZE_CTRL: reg_rdata_o <= {halt_core_select_reg, cpu_throttle_enable_reg,
					restore_on_irq_reg, throttle_on_return_reg, 1'b0, throttle_ratio_select_reg};
				`ADDR_VREG_CTRL: reg_rdata_o <= {6'h00, regulator_lowpower_select_reg, 1'b1};
				`ADDR_STATUS: reg_rdata_o <= {3'h0, timeout_flag_o, powerdown_flag_o, state_reg};
				`ADDR_WAKE_CAUSE: reg_rdata_o <= {5'h00, wake_cause_reg};
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

endmodule
`default_nettype wire

// *** tb/cpu_power_mode_control_chk.sv ***
// Concurrent checks on the ports of the CPU power-mode control block
`timescale 1ns/1ps
`default_nettype none
module cpu_power_mode_control_chk (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic global_irq_enable_i,
	input wire logic clock_output_pin_enable_i,
	input wire logic core_clk_en_o,
	input wire logic periph_clk_en_o,
	input wire logic sysosc_periph_en_o,
	input wire logic lowfreq_osc_en_o,
	input wire logic io_hold_o,
	input wire logic wdt_clear_o,
	input wire logic wdt_reset_block_o,
	input wire logic regulator_lowpower_o,
	input wire logic clock_output_pin_en_o,
	input wire logic vector_to_handler_o,
	input wire logic [15:0] handler_addr_o,
	input wire logic powerdown_flag_o,
	input wire logic timeout_flag_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	a_periph_running: assert property (periph_clk_en_o)
		else $error("peripheral clock enable dropped");
	a_lowfreq_running: assert property (lowfreq_osc_en_o)
		else $error("low-frequency oscillator enable dropped");
	a_sleep_clocks_off: assert property (io_hold_o |-> !core_clk_en_o && !sysosc_periph_en_o)
		else $error("core or system-clock peripherals run in sleep");
	a_sleep_flags: assert property (io_hold_o |-> !powerdown_flag_o && timeout_flag_o)
		else $error("status flags wrong in sleep");
	a_sleep_wdt_clear: assert property ($rose(io_hold_o) |-> wdt_clear_o || $past(wdt_clear_o))
		else $error("watchdog not cleared on sleep entry");
	a_idle_core_halt: assert property (wdt_reset_block_o |-> !core_clk_en_o && !io_hold_o && sysosc_periph_en_o)
		else $error("idle clocks wrong");
	a_vector_addr: assert property (!$past(sys_rst_i) |-> handler_addr_o == 16'h0004)
		else $error("handler address wrong");
	a_clock_output_pin_idle: assert property (wdt_reset_block_o && $past(wdt_reset_block_o) && $past(clock_output_pin_enable_i)
		|-> clock_output_pin_en_o)
		else $error("clock output stopped in idle");
	a_vector_gie: assert property (vector_to_handler_o |-> $past(global_irq_enable_i))
		else $error("vector without global enable");
	a_regulator_sleep: assert property (regulator_lowpower_o |-> io_hold_o)
		else $error("regulator low power outside sleep");
	cover property ($rose(io_hold_o));
	cover property ($rose(wdt_reset_block_o));
	cover property (vector_to_handler_o);
	cover property (regulator_lowpower_o);
endmodule
bind cpu_power_mode_control cpu_power_mode_control_chk cpu_power_mode_control_chk_i (.clk_sys_i(clk_sys_i),
	.sys_rst_i(sys_rst_i), .global_irq_enable_i(global_irq_enable_i), .core_clk_en_o(core_clk_en_o),
	.clock_output_pin_enable_i(clock_output_pin_enable_i), .periph_clk_en_o(periph_clk_en_o),
	.sysosc_periph_en_o(sysosc_periph_en_o), .lowfreq_osc_en_o(lowfreq_osc_en_o), .io_hold_o(io_hold_o),
	.wdt_clear_o(wdt_clear_o), .wdt_reset_block_o(wdt_reset_block_o), .regulator_lowpower_o(regulator_lowpower_o),
	.clock_output_pin_en_o(clock_output_pin_en_o), .vector_to_handler_o(vector_to_handler_o),
	.handler_addr_o(handler_addr_o), .powerdown_flag_o(powerdown_flag_o), .timeout_flag_o(timeout_flag_o));
`default_nettype wire

// *** tb/cpu_power_mode_control_tb_top.sv ***
// Self-checking testbench for the CPU power-mode control block
`timescale 1ns/1ps
`default_nettype none
`include "pwr_mode_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module cpu_power_mode_control_tb_top;
	logic clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, sleep_instr_i, irq_entry_i, return_from_irq_instr_i;
	logic irq_pending_i, global_irq_enable_i, wdt_timeout_i, wdt_sleep_enable_i, crystal_mode_i, lp;
	logic clock_output_pin_enable_i;
	logic [`ADDR_W-1:0] reg_addr_i;
	logic [`DATA_W-1:0] reg_wdata_i, reg_rdata_o;
	logic core_clk_en_o, periph_clk_en_o, sysosc_periph_en_o, lowfreq_osc_en_o, io_hold_o, wdt_clear_o;
	logic wdt_reset_block_o, regulator_lowpower_o, clock_output_pin_en_o, wake_pulse_o, vector_to_handler_o;
	logic powerdown_flag_o, timeout_flag_o;
	logic [15:0] handler_addr_o;
	int n_mismatch = 0, checks_done = 0, cyc = 0, n_vec = 0, n_clr = 0, hi_n, lo_n, r;
	logic [7:0] cfg [3] = '{8'h41, 8'h61, 8'h11};
	logic [7:0] exp_doze [3] = '{8'h41, 8'h21, 8'h51};
	cpu_power_mode_control cpu_power_mode_control_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .sleep_instr_i(sleep_instr_i), .irq_entry_i(irq_entry_i),
		.return_from_irq_instr_i(return_from_irq_instr_i), .irq_pending_i(irq_pending_i),
		.global_irq_enable_i(global_irq_enable_i), .wdt_timeout_i(wdt_timeout_i),
		.wdt_sleep_enable_i(wdt_sleep_enable_i), .crystal_mode_i(crystal_mode_i),
		.clock_output_pin_enable_i(clock_output_pin_enable_i), .core_clk_en_o(core_clk_en_o),
		.periph_clk_en_o(periph_clk_en_o), .sysosc_periph_en_o(sysosc_periph_en_o),
		.lowfreq_osc_en_o(lowfreq_osc_en_o), .io_hold_o(io_hold_o), .wdt_clear_o(wdt_clear_o),
		.wdt_reset_block_o(wdt_reset_block_o), .regulator_lowpower_o(regulator_lowpower_o),
		.clock_output_pin_en_o(clock_output_pin_en_o), .wake_pulse_o(wake_pulse_o),
		.vector_to_handler_o(vector_to_handler_o), .handler_addr_o(handler_addr_o),
		.powerdown_flag_o(powerdown_flag_o), .timeout_flag_o(timeout_flag_o));
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	// Counts registered pulses as they stand before each edge lands
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (vector_to_handler_o === 1'b1) n_vec++;
		if (wdt_clear_o === 1'b1) n_clr++;
		if (cyc == 10000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] e);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		`CHK(reg_rdata_o, e)
	endtask
	task automatic nap(input logic idle, input logic by_wdt, input logic global_irq_enable, input int lo, input int hi);
		int n;
		int v0;
		int c0;
		v0 = n_vec;
		c0 = n_clr;
		@(posedge clk_sys_i);
		global_irq_enable_i <= global_irq_enable;
		sleep_instr_i <= 1'b1;
		@(posedge clk_sys_i);
		sleep_instr_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1;
		`CHK({core_clk_en_o, io_hold_o, wdt_reset_block_o, sysosc_periph_en_o}, {1'b0, !idle, idle, idle})
		if (!idle) `CHK({powerdown_flag_o, timeout_flag_o, regulator_lowpower_o}, {2'b01, lp})
		@(posedge clk_sys_i);
		if (by_wdt) wdt_timeout_i <= 1'b1;
		else irq_pending_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (wake_pulse_o !== 1'b1 && n < 1200);
		`CHK(n >= lo && n <= hi, 1'b1)
		@(posedge clk_sys_i);
		irq_pending_i <= 1'b0;
		wdt_timeout_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		`CHK(n_vec != v0, global_irq_enable & !by_wdt)
		if (!idle) `CHK(n_clr - c0 >= 2, 1'b1)
		$display("test nap idle=%0d wdt=%0d done", idle, by_wdt);
	endtask
	initial begin
		{sys_rst_i, reg_wr_i, reg_rd_i, sleep_instr_i, irq_entry_i, return_from_irq_instr_i} = 6'h20;
		{irq_pending_i, global_irq_enable_i, wdt_timeout_i, crystal_mode_i, lp} = 5'h00;
		{wdt_sleep_enable_i, clock_output_pin_enable_i, reg_addr_i, reg_wdata_i} = '1;
		void'($urandom(32'h5be8));
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rd(4'hF, 8'h00);
		rd(`ADDR_VREG_CTRL, `VREG_CTRL_RST);
		r = $urandom % 8;
		for (int k = 0; k < 8; k++) begin
			r = (r + 1) % 8;
			wr(`ADDR_DOZE_CTRL, 8'h40 | r[7:0]);
			repeat (4 + $urandom % 4) @(posedge clk_sys_i);
			hi_n = 0;
			lo_n = 0;
			repeat (4 << r) begin
				@(posedge clk_sys_i);
				#1;
				hi_n += (core_clk_en_o === 1'b1);
				lo_n += (periph_clk_en_o !== 1'b1);
			end
			`CHK(hi_n, 2)
			`CHK(lo_n, 0)
		end
		$display("test throttle ratios done");
		for (int k = 0; k < 3; k++) begin
			r = $urandom % 8;
			wr(`ADDR_DOZE_CTRL, cfg[k] | r[7:0]);
			@(posedge clk_sys_i);
			if (k < 2) irq_entry_i <= 1'b1;
			else return_from_irq_instr_i <= 1'b1;
			@(posedge clk_sys_i);
			{irq_entry_i, return_from_irq_instr_i} <= 2'b00;
			rd(`ADDR_DOZE_CTRL, exp_doze[k] | r[7:0]);
		end
		$display("test irq throttle done");
		wr(`ADDR_DOZE_CTRL, 8'h00);
		irq_pending_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		sleep_instr_i <= 1'b1;
		@(posedge clk_sys_i);
		sleep_instr_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1;
		`CHK({io_hold_o, powerdown_flag_o, timeout_flag_o}, 3'b011)
		rd(`ADDR_WAKE_CAUSE, 8'h04);
		irq_pending_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		$display("test pending noop done");
		nap(1'b0, 1'b0, 1'b1, 1, 8);
		nap(1'b0, 1'b0, 1'b0, 1, 8);
		nap(1'b0, 1'b1, 1'b0, 1, 8);
		crystal_mode_i <= 1'b1;
		nap(1'b0, 1'b0, 1'b1, `OST_PERIODS + 1, `OST_PERIODS + 8);
		crystal_mode_i <= 1'b0;
		lp = 1'b1;
		wr(`ADDR_VREG_CTRL, 8'h03);
		nap(1'b0, 1'b0, 1'b0, 101, 108);
		lp = 1'b0;
		wr(`ADDR_VREG_CTRL, 8'h01);
		wr(`ADDR_DOZE_CTRL, 8'hE1);
		nap(1'b1, 1'b1, 1'b0, 1, 8);
		rd(`ADDR_DOZE_CTRL, 8'hE1);
		nap(1'b1, 1'b0, 1'b0, 1, 8);
		rd(`ADDR_DOZE_CTRL, 8'hA1);
		test_done();
	end
endmodule
`default_nettype wire
